//--- emle_cfg.svh
// How it works
// RULE1: memory holds 100 effect registers, ten banks of ten
// RULE2: each level is enabled+delegated, enabled only, or neither
// RULE3: tied mode press inverts only that level's enable
// RULE4: tied mode treats every enabled level as delegated
// RULE5: selective mode delegates only explicitly chosen enabled levels
// RULE6: selective mode press on idle level makes it enabled and delegated
// RULE7: selective mode press on enabled level toggles delegation only
// RULE8: operator clears an enable by returning to tied mode, then pressing
// RULE9: learn, recall, put, get and run act on all enabled levels
// RULE10: learn and keyframe insert capture only enabled levels
// RULE11: tally high when delegated, low when enabled only, else off
// RULE12: cut, copy, paste and modify touch delegated levels only
// RULE13: master timeline merges keyframes of all enabled levels
// RULE14: clipboard keeps a separate slot for every level
// RULE15: keyframe add or modify refused without edit mode and target levels
// RULE16: running effect drives live state with interpolated keyframe values
// RULE17: recall restores the learned state at once
// RULE18: mode is one stored bit; level states survive mode changes
`ifndef EMLE_CFG_SVH
`define EMLE_CFG_SVH
`define EMLE_NLVL      8
`define EMLE_DW        16
`define EMLE_NBANK     10
`define EMLE_PER_BANK  10
`define EMLE_NREG      (`EMLE_NBANK * `EMLE_PER_BANK)
`define EMLE_NKF       2
// register word addresses
`define EMLE_A_CTRL    8'h00
`define EMLE_A_STAT    8'h01
`define EMLE_A_PRESS   8'h02
`define EMLE_A_CMD     8'h03
`define EMLE_A_POS     8'h04
`define EMLE_A_MTL     8'h05
`define EMLE_A_LIVE    8'h10
// field positions
`define EMLE_B_SEL     0
`define EMLE_B_EDIT    1
`define EMLE_B_RUN     16
`define EMLE_B_REFUSE  17
`define EMLE_B_KF      16
`define EMLE_CTRL_RST  2'h0
// run timing
`define EMLE_CLK_NS    50
`define EMLE_TICK_NS   1000000
`define EMLE_POS_MAX   8'hFF
`endif

//--- emle_pkg.sv
`default_nettype none
package emle_pkg;
  // command codes written to the command register
  typedef enum logic [3:0] {
    EMLE_LEARN, EMLE_RECALL, EMLE_PUT, EMLE_GET, EMLE_RUN,
    EMLE_INSERT, EMLE_MODIFY, EMLE_CUT, EMLE_COPY, EMLE_PASTE
  } emle_op_t;
endpackage
`default_nettype wire

//--- emle_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "emle_cfg.svh"
module emle_top
  import emle_pkg::*;
#(
  parameter int RUN_TICK_CYC = `EMLE_TICK_NS / `EMLE_CLK_NS
) (
  input  wire logic                            CLK_I,
  input  wire logic                            RST_N_I,
  input  wire logic [7:0]                      ADDR_I,
  input  wire logic [31:0]                     WDATA_I,
  input  wire logic                            WR_I,
  input  wire logic                            RD_I,
  output logic      [31:0]                     RDATA_O,
  input  wire logic [`EMLE_NLVL-1:0]           BTN_I,
  output logic      [`EMLE_NLVL-1:0]           TALLY_HI_O,
  output logic      [`EMLE_NLVL-1:0]           TALLY_LO_O,
  output logic      [`EMLE_NLVL*`EMLE_DW-1:0]  LIVE_O
);
  localparam int NL = `EMLE_NLVL;
  localparam int DW = `EMLE_DW;

  // interpolate between two keyframe values, position in 1/256 steps
  function automatic logic [DW-1:0] lerp(input logic [DW-1:0] a,
                                         input logic [DW-1:0] b,
                                         input logic [7:0]    p);
    logic signed [DW:0]   d;
    logic signed [DW+9:0] m;
    d = $signed({1'b0, b}) - $signed({1'b0, a});
    m = d * $signed({1'b0, p});
    lerp = a + m[DW+7:8];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]          ctrl_q;
  logic [NL-1:0]       en_q;
  logic [NL-1:0]       del_q;
  logic [NL-1:0]       eff_del;
  logic [NL-1:0]       btn_s1_q, btn_s2_q, btn_s3_q;
  logic [NL-1:0]       press;
  logic [DW-1:0]       live_q [NL];
  logic [DW-1:0]       kf_mem [`EMLE_NREG][`EMLE_NKF][NL];
  logic [NL-1:0]       kf_vld_q [`EMLE_NREG][`EMLE_NKF];
  logic [DW-1:0]       clip_q [NL];
  logic [NL-1:0]       clip_vld_q;
  logic                run_q;
  logic [6:0]          run_reg_q;
  logic [6:0]          sel_reg_q;
  logic [7:0]          pos_q;
  logic [31:0]         tick_cnt_q;
  logic                tick;
  logic                refused_q;
  logic [31:0]         rdata_q;

  logic                sel_mode, edit_en;
  logic                cmd_go, acc, refuse;
  emle_op_t            op;
  logic [6:0]          c_reg;
  logic                c_kf;
  logic [NL-1:0]       mask;
  logic                wr_kf;

  assign sel_mode = ctrl_q[`EMLE_B_SEL];
  assign edit_en  = ctrl_q[`EMLE_B_EDIT];

  //////////////////////////////////////////////////////////////////////////////
  // control register: mode is one stored bit, level states untouched
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= `EMLE_CTRL_RST;
    end else if (WR_I && ADDR_I == `EMLE_A_CTRL) begin
      ctrl_q <= WDATA_I[1:0]; // RULE18
    end
  end

  // panel buttons are async pins: two flops, then edge detect on the third
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      btn_s1_q <= '0;
      btn_s2_q <= '0;
      btn_s3_q <= '0;
    end else begin
      btn_s1_q <= BTN_I;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
    end
  end

  assign press = (btn_s2_q & ~btn_s3_q) | ((WR_I && ADDR_I == `EMLE_A_PRESS) ? WDATA_I[NL-1:0] : '0);

  // tied mode: delegation mirrors enable; stored delegates kept for later, except a tied press sets its level's delegate to the new enable
  assign eff_del = sel_mode ? del_q : en_q; // RULE4 RULE5

  //////////////////////////////////////////////////////////////////////////////
  // enable and delegate bits; delegate never set without enable
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_q  <= '0;
      del_q <= '0;
    end else begin
      for (int l = 0; l < NL; l++) begin
        if (press[l]) begin
          if (!sel_mode) begin
            en_q[l]  <= ~en_q[l]; // RULE3
            del_q[l] <= ~en_q[l]; // RULE2
          end else if (!en_q[l]) begin
            en_q[l]  <= 1'b1; // RULE6
            del_q[l] <= 1'b1; // RULE6
          end else begin
            del_q[l] <= ~del_q[l]; // RULE7
          end
        end
      end
    end
  end

  // tallies registered so the lamps never glitch
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      TALLY_HI_O <= '0;
      TALLY_LO_O <= '0;
    end else begin
      TALLY_HI_O <= eff_del;         // RULE11
      TALLY_LO_O <= en_q & ~eff_del; // RULE11
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode; bank and slot form a flat index 0..99
  assign cmd_go = WR_I && ADDR_I == `EMLE_A_CMD;
  assign op     = emle_op_t'(WDATA_I[3:0]);
  assign c_reg  = WDATA_I[14:8];
  assign c_kf   = WDATA_I[`EMLE_B_KF];

  always_comb begin
    mask  = en_q; // RULE9
    wr_kf = c_kf;
    case (op)
      EMLE_LEARN:  wr_kf = 1'b0;
      EMLE_INSERT: mask  = en_q;    // RULE10
      EMLE_MODIFY, EMLE_CUT, EMLE_COPY, EMLE_PASTE:
        mask = eff_del;             // RULE12
      default:     mask  = en_q;
    endcase
  end

  // out-of-range register or unknown code is refused; edits need edit mode
  always_comb begin
    refuse = (c_reg >= 7'(`EMLE_NREG)) || (op > EMLE_PASTE); // RULE1
    case (op)
      EMLE_INSERT, EMLE_MODIFY, EMLE_CUT, EMLE_PASTE:
        refuse = refuse || !edit_en || mask == '0; // RULE15
      default: refuse = refuse;
    endcase
  end
  assign acc = cmd_go && !refuse;

  // refusal flag: write one to clear, a new refusal wins over the clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      refused_q <= 1'b0;
    end else if (cmd_go && refuse) begin
      refused_q <= 1'b1; // RULE15
    end else if (WR_I && ADDR_I == `EMLE_A_STAT && WDATA_I[`EMLE_B_REFUSE]) begin
      refused_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_reg_q <= '0;
    end else if (acc) begin
      sel_reg_q <= c_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // keyframe storage; data array has no reset, valid bits do
  always_ff @(posedge CLK_I) begin
    if (acc) begin
      for (int l = 0; l < NL; l++) begin
        if (mask[l]) begin
          case (op)
            EMLE_LEARN, EMLE_PUT, EMLE_INSERT, EMLE_MODIFY:
              kf_mem[c_reg][wr_kf][l] <= live_q[l]; // RULE10
            EMLE_PASTE:
              if (clip_vld_q[l]) kf_mem[c_reg][wr_kf][l] <= clip_q[l]; // RULE14
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int r = 0; r < `EMLE_NREG; r++) begin
        for (int k = 0; k < `EMLE_NKF; k++) kf_vld_q[r][k] <= '0;
      end
    end else if (acc) begin
      case (op)
        EMLE_LEARN: begin
          kf_vld_q[c_reg][0] <= kf_vld_q[c_reg][0] | mask;
          kf_vld_q[c_reg][1] <= kf_vld_q[c_reg][1] & ~mask;
        end
        EMLE_PUT, EMLE_INSERT, EMLE_MODIFY:
          kf_vld_q[c_reg][wr_kf] <= kf_vld_q[c_reg][wr_kf] | mask;
        EMLE_PASTE:
          kf_vld_q[c_reg][wr_kf] <= kf_vld_q[c_reg][wr_kf] | (mask & clip_vld_q);
        EMLE_CUT:
          kf_vld_q[c_reg][wr_kf] <= kf_vld_q[c_reg][wr_kf] & ~mask; // RULE12
        default: ;
      endcase
    end
  end

  // clipboard, one slot per level, only masked levels overwritten
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clip_vld_q <= '0;
      for (int l = 0; l < NL; l++) clip_q[l] <= '0;
    end else if (acc && (op == EMLE_CUT || op == EMLE_COPY)) begin
      for (int l = 0; l < NL; l++) begin
        if (mask[l]) begin
          clip_q[l]     <= kf_mem[c_reg][c_kf][l];    // RULE14
          clip_vld_q[l] <= kf_vld_q[c_reg][c_kf][l];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // run rate divider: one-cycle tick per position step
  assign tick = run_q && tick_cnt_q == 32'(RUN_TICK_CYC - 1);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick_cnt_q <= '0;
    end else if (!run_q || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // run sequencer; current time is the master timeline position
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      run_q     <= 1'b0;
      run_reg_q <= '0;
      pos_q     <= '0;
    end else if (acc && op == EMLE_RUN) begin
      run_q     <= 1'b1; // RULE9
      run_reg_q <= c_reg;
      pos_q     <= '0;
    end else if (acc && op == EMLE_RECALL) begin
      run_q     <= 1'b0;
      pos_q     <= '0;
    end else if (tick) begin
      pos_q <= pos_q + 8'h1; // RULE13
      if (pos_q == `EMLE_POS_MAX - 8'h1) run_q <= 1'b0;
    end else if (!run_q && WR_I && ADDR_I == `EMLE_A_POS) begin
      pos_q <= WDATA_I[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // live state buffer: recall/get, then running interpolation, then software load
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int l = 0; l < NL; l++) live_q[l] <= '0;
    end else begin
      for (int l = 0; l < NL; l++) begin
        if (acc && (op == EMLE_RECALL || op == EMLE_GET)) begin
          if (en_q[l] && kf_vld_q[c_reg][wr_kf && op == EMLE_GET][l])
            live_q[l] <= kf_mem[c_reg][wr_kf && op == EMLE_GET][l]; // RULE17 RULE9
        end else if (run_q && en_q[l] && kf_vld_q[run_reg_q][0][l] && kf_vld_q[run_reg_q][1][l]) begin
          live_q[l] <= lerp(kf_mem[run_reg_q][0][l], kf_mem[run_reg_q][1][l], pos_q); // RULE16
        end else if (WR_I && ADDR_I == `EMLE_A_LIVE + 8'(l)) begin
          live_q[l] <= WDATA_I[DW-1:0];
        end
      end
    end
  end

  always_comb begin
    for (int l = 0; l < NL; l++) LIVE_O[l*DW +: DW] = live_q[l];
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data valid the cycle after the strobe, unmapped reads zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= '0;
    end else if (RD_I) begin
      rdata_q <= '0;
      if (ADDR_I == `EMLE_A_CTRL) rdata_q <= {30'h0, ctrl_q};
      else if (ADDR_I == `EMLE_A_STAT)
        rdata_q <= {14'h0, refused_q, run_q, eff_del, en_q};
      else if (ADDR_I == `EMLE_A_POS) rdata_q <= {24'h0, pos_q};
      else if (ADDR_I == `EMLE_A_MTL) // RULE13
        rdata_q <= {30'h0, |(kf_vld_q[sel_reg_q][1] & en_q), |(kf_vld_q[sel_reg_q][0] & en_q)};
      else if (ADDR_I >= `EMLE_A_LIVE && ADDR_I < `EMLE_A_LIVE + 8'(NL))
        rdata_q <= {16'h0, live_q[3'(ADDR_I - `EMLE_A_LIVE)]};
    end
  end
  assign RDATA_O = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_tied_press;
    !sel_mode && press != '0;
  endsequence
  sequence s_sel_press;
    sel_mode && press != '0;
  endsequence

  property p_del_subset;
    @(posedge CLK_I) disable iff (!RST_N_I) (del_q & ~en_q) == '0;
  endproperty
  a_del_subset: assert property (p_del_subset) else $error("delegate without enable"); // RULE2

  property p_tied_toggle;
    @(posedge CLK_I) disable iff (!RST_N_I) s_tied_press |=> en_q == ($past(en_q) ^ $past(press));
  endproperty
  a_tied_toggle: assert property (p_tied_toggle) else $error("tied press bad"); // RULE3

  property p_tied_follow;
    @(posedge CLK_I) disable iff (!RST_N_I) !sel_mode |-> eff_del == en_q;
  endproperty
  a_tied_follow: assert property (p_tied_follow) else $error("tied delegate mismatch"); // RULE4

  property p_sel_new;
    @(posedge CLK_I) disable iff (!RST_N_I)
      s_sel_press |=> (en_q & del_q & $past(press & ~en_q)) == $past(press & ~en_q);
  endproperty
  a_sel_new: assert property (p_sel_new) else $error("new level not enabled+delegated"); // RULE6

  property p_sel_keep;
    @(posedge CLK_I) disable iff (!RST_N_I) s_sel_press |=> (en_q & $past(en_q)) == $past(en_q);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("selective press cleared enable"); // RULE7

  property p_tally;
    @(posedge CLK_I) disable iff (!RST_N_I)
      ##1 (TALLY_HI_O == $past(eff_del)) && (TALLY_LO_O == $past(en_q & ~eff_del));
  endproperty
  a_tally: assert property (p_tally) else $error("tally mismatch"); // RULE11

  property p_refuse;
    @(posedge CLK_I) disable iff (!RST_N_I)
      cmd_go && !edit_en && (op == EMLE_INSERT || op == EMLE_MODIFY) |=> refused_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("edit accepted without edit mode"); // RULE15

  property p_mode_keep;
    @(posedge CLK_I) disable iff (!RST_N_I)
      WR_I && ADDR_I == `EMLE_A_CTRL && press == '0 |=> en_q == $past(en_q) && del_q == $past(del_q);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode change altered levels"); // RULE18

  property p_run_step;
    @(posedge CLK_I) disable iff (!RST_N_I) tick && !cmd_go |=> pos_q == $past(pos_q) + 8'h1;
  endproperty
  a_run_step: assert property (p_run_step) else $error("run position stalled"); // RULE16

endmodule
`default_nettype wire

//--- emle_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module emle_panel_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [2:0] lvl_i,
  output logic      [7:0] btn_o,
  output logic            busy_o
);
  logic [2:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // one press: pin high for 3 edges, then low for 3 more
  // low spell keeps the minimum release time between presses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 3'h0;
      btn_o <= 8'h00;
    end else if (cnt_q == 3'h0) begin
      if (req_i) begin
        cnt_q <= 3'h6;
        btn_o <= 8'h01 << lvl_i;
      end
    end else begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h4) begin
        btn_o <= 8'h00; // released button reads low
      end
    end
  end

  // busy while a press is still in flight
  assign busy_o = (cnt_q != 3'h0);
endmodule
`default_nettype wire

//--- emle_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "emle_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module emle_top_bench
  import emle_pkg::*;
;
  logic                           clk, rst_n, wr, rd, preq, pbusy;
  logic [7:0]                     addr, btn, t_hi, t_lo;
  logic [2:0]                     plvl;
  logic [31:0]                    wdata, rdata, v;
  logic [`EMLE_NLVL*`EMLE_DW-1:0] live;
  logic [15:0]                    exp_l [8];
  int                             n_errors, num_checks, k;

  ////////////////////////////////////////////////////////////////////////////
  // short run tick keeps a full sweep near a thousand cycles
  emle_top #(.RUN_TICK_CYC(4)) dut_u (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BTN_I(btn), .TALLY_HI_O(t_hi), .TALLY_LO_O(t_lo), .LIVE_O(live));
  emle_panel_model panel_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(preq), .lvl_i(plvl), .btn_o(btn),
    .busy_o(pbusy));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus cycles, one strobe cycle each
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // data stands from the cycle after the strobe until the next read strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, v);
    `CHK(v, e)
  endtask
  task automatic cmd(input logic [3:0] op, input logic [6:0] r, input logic s);
    wr_reg(`EMLE_A_CMD, {15'h0000, s, 1'b0, r, 4'h0, op});
  endtask
  task automatic clr_ref();
    wr_reg(`EMLE_A_STAT, 32'h0002_0000);
  endtask
  // fixed wait covers sync, update and tally stages of one press
  task automatic press(input logic [2:0] l);
    while (pbusy) @(posedge clk);
    @(posedge clk);
    preq <= 1'b1;
    plvl <= l;
    @(posedge clk);
    preq <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic set_live(input logic [15:0] b, input logic [15:0] s);
    for (int l = 0; l < 8; l++) wr_reg(8'(`EMLE_A_LIVE + l), {16'h0000, 16'(b + s * l)});
  endtask
  task automatic set_exp(input logic [7:0] m, input logic [15:0] a, input logic [15:0] b);
    for (int l = 0; l < 8; l++) exp_l[l] = m[l] ? 16'(a + l) : 16'(b + l);
  endtask
  task automatic chk_live();
    #1;
    for (int l = 0; l < 8; l++) `CHK(live[16*l +: 16], exp_l[l])
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well past the expected run of under fifteen hundred cycles
  initial begin
    repeat (10000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  // main sequence
  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; preq = 1'b0; plvl = 3'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk_reg(`EMLE_A_STAT, 32'h0000_0000);
    chk_reg(`EMLE_A_CTRL, 32'h0000_0000);
    `CHK({t_hi, t_lo}, 16'h0000)
    $display("test reset done");
    press(3'h2);
    chk_reg(`EMLE_A_STAT, 32'h0000_0404);
    `CHK(t_hi, 8'h04)
    wr_reg(`EMLE_A_PRESS, 32'h21);
    chk_reg(`EMLE_A_STAT, 32'h0000_2525);
    wr_reg(`EMLE_A_PRESS, 32'h25);
    chk_reg(`EMLE_A_STAT, 32'h0000_0000);
    settle();
    `CHK(t_hi | t_lo, 8'h00)
    $display("test tied done");
    wr_reg(`EMLE_A_CTRL, 32'h1);
    wr_reg(`EMLE_A_PRESS, 32'h25);
    chk_reg(`EMLE_A_STAT, 32'h0000_2525);
    press(3'h5);
    chk_reg(`EMLE_A_STAT, 32'h0000_0525);
    `CHK(t_hi, 8'h05)
    `CHK(t_lo, 8'h20)
    wr_reg(`EMLE_A_CTRL, 32'h0);
    chk_reg(`EMLE_A_STAT, 32'h0000_2525);
    wr_reg(`EMLE_A_CTRL, 32'h1);
    chk_reg(`EMLE_A_STAT, 32'h0000_0525);
    $display("test selective done");
    // learn then recall touches enabled levels only
    set_live(16'h1000, 16'h0001);
    cmd(EMLE_LEARN, 7'h07, 1'b0);
    set_live(16'h2000, 16'h0001);
    cmd(EMLE_RECALL, 7'h07, 1'b0);
    set_exp(8'h25, 16'h1000, 16'h2000);
    chk_live();
    // clipboard round trip over delegated levels
    cmd(EMLE_COPY, 7'h07, 1'b0);
    set_live(16'h3000, 16'h0001);
    wr_reg(`EMLE_A_CTRL, 32'h3);
    cmd(EMLE_PASTE, 7'h08, 1'b0);
    cmd(EMLE_RECALL, 7'h08, 1'b0);
    set_exp(8'h05, 16'h1000, 16'h3000);
    chk_live();
    chk_reg(`EMLE_A_MTL, 32'h0000_0001);
    $display("test memory done");
    wr_reg(`EMLE_A_CTRL, 32'h1);
    cmd(EMLE_INSERT, 7'h08, 1'b1);
    chk_reg(`EMLE_A_STAT, 32'h0002_0525);
    clr_ref();
    cmd(EMLE_LEARN, 7'd100, 1'b0);
    chk_reg(`EMLE_A_STAT, 32'h0002_0525);
    clr_ref();
    cmd(EMLE_LEARN, 7'd99, 1'b0);
    chk_reg(`EMLE_A_STAT, 32'h0000_0525);
    $display("test refuse done");
    // sweep from zero to a per-level ramp
    wr_reg(`EMLE_A_CTRL, 32'h3);
    set_live(16'h0000, 16'h0000);
    cmd(EMLE_LEARN, 7'h03, 1'b0);
    set_live(16'h0100, 16'h0100);
    cmd(EMLE_INSERT, 7'h03, 1'b1);
    cmd(EMLE_RUN, 7'h03, 1'b0);
    chk_reg(`EMLE_A_STAT, 32'h0003_0525 & 32'hFFFD_FFFF);
    k = 0;
    do begin
      rd_reg(`EMLE_A_STAT, v);
      k++;
    end while (v[16] === 1'b1 && k < 1000);
    `CHK(v[16], 1'b0)
    chk_reg(`EMLE_A_POS, 32'h0000_00FF);
    // last live update used position 254: the stop and the final step share one edge
    for (int l = 0; l < 8; l++) exp_l[l] = 16'((l + 1) * ((8'h25 >> l) & 1 ? 16'h00FE : 16'h0100));
    chk_live();
    $display("test run done");
    // put, get, modify, cut and paste on a fresh register
    wr_reg(`EMLE_A_POS, 32'h40);
    chk_reg(`EMLE_A_POS, 32'h0000_0040);
    set_live(16'h4000, 16'h0001);
    cmd(EMLE_PUT, 7'h0A, 1'b0);
    set_live(16'h5000, 16'h0001);
    cmd(EMLE_GET, 7'h0A, 1'b0);
    set_exp(8'h25, 16'h4000, 16'h5000);
    chk_live();
    set_live(16'h6000, 16'h0001);
    cmd(EMLE_MODIFY, 7'h0A, 1'b0);
    cmd(EMLE_CUT, 7'h0A, 1'b0);
    set_live(16'h7000, 16'h0001);
    cmd(EMLE_GET, 7'h0A, 1'b0);
    set_exp(8'h20, 16'h4000, 16'h7000);
    chk_live();
    cmd(EMLE_PASTE, 7'h0A, 1'b1);
    set_live(16'h7000, 16'h0001);
    cmd(EMLE_GET, 7'h0A, 1'b1);
    set_exp(8'h05, 16'h6000, 16'h7000);
    chk_live();
    chk_reg(`EMLE_A_LIVE + 8'h02, 32'h0000_6002);
    chk_reg(`EMLE_A_MTL, 32'h0000_0003);
    $display("test edit done");
    wr_reg(`EMLE_A_CTRL, 32'h0);
    press(3'h5);
    chk_reg(`EMLE_A_STAT, 32'h0000_0505);
    `CHK(t_hi, 8'h05)
    `CHK(t_lo, 8'h00)
    $display("test clear done");
    conclude();
  end
endmodule
`default_nettype wire
